/* File: wdt_pkg.sv */
// Constants shared by the watchdog and interval timer files.
// Assumes one system clock; one state equals one clock cycle.
package wdt_pkg;

  // Register addresses on the internal register bus
  localparam logic [15:0] WDT_ADDR_CTRL_STAT = 16'hFFBC;
  localparam logic [15:0] WDT_ADDR_COUNT     = 16'hFFBD;
  localparam logic [15:0] WDT_ADDR_RST_WR    = 16'hFFBE;
  localparam logic [15:0] WDT_ADDR_RST_RD    = 16'hFFBF;

  // Write keys carried in the upper byte; flag clear data in the lower byte
  localparam logic [7:0] WDT_KEY_COUNT     = 8'h5A;
  localparam logic [7:0] WDT_KEY_CTRL      = 8'hA5;
  localparam logic [7:0] WDT_KEY_RST_BITS  = 8'h5A;
  localparam logic [7:0] WDT_KEY_FLAG_CLR  = 8'hA5;
  localparam logic [7:0] WDT_FLAG_CLR_DATA = 8'h00;

  // Values after reset, and the counter maximum
  localparam logic [7:0] WDT_CTRL_STAT_RST = 8'h18;
  localparam logic [7:0] WDT_RST_CTRL_RST  = 8'h1F;
  localparam logic [7:0] WDT_COUNT_RST     = 8'h00;
  localparam logic [7:0] WDT_COUNT_MAX     = 8'hFF;

  // Field positions
  localparam int WDT_BIT_IOVF     = 7;
  localparam int WDT_BIT_MODE     = 6;
  localparam int WDT_BIT_RUN      = 5;
  localparam int WDT_BIT_CKS_HI   = 2;
  localparam int WDT_BIT_WATCHDOG_OVERFLOW_FLAG     = 7;
  localparam int WDT_BIT_RST_EN   = 6;
  localparam int WDT_BIT_RST_TYPE = 5;

  // Reserved bits reading as one
  localparam logic [1:0] WDT_CTRL_RSVD = 2'h3;
  localparam logic [4:0] WDT_RST_RSVD  = 5'h1F;

  // Timing in states, then cycles
  localparam int WDT_CYC_PER_STATE      = 1;
  localparam int WDT_OUT_STATES_RST_EN  = 132;
  localparam int WDT_OUT_STATES_RST_DIS = 130;
  localparam int WDT_CHIP_RST_STATES    = 518;
  localparam int WDT_PULSE_W            = 10;
  localparam logic [9:0] WDT_OUT_CYC_RST_EN  = 10'(WDT_OUT_STATES_RST_EN * WDT_CYC_PER_STATE);
  localparam logic [9:0] WDT_OUT_CYC_RST_DIS = 10'(WDT_OUT_STATES_RST_DIS * WDT_CYC_PER_STATE);
  localparam logic [9:0] WDT_CHIP_RST_CYC    = 10'(WDT_CHIP_RST_STATES * WDT_CYC_PER_STATE);

  // Prescaler: log2 of each division, select 0 to 7
  localparam int WDT_PRE_WIDTH = 17;
  localparam logic [39:0] WDT_DIV_LOG2 = {5'h11, 5'h0F, 5'h0D, 5'h0B, 5'h09, 5'h07, 5'h06, 5'h01};

endpackage : wdt_pkg

/* File: wdt_prescaler.sv */
// Free running divider giving one tick pulse per selected division.
// Assumes an asynchronous active low reset already released cleanly.
`timescale 1ns/100ps
module wdt_prescaler #(
  parameter int WIDTH = wdt_pkg::WDT_PRE_WIDTH
) (
  input  logic       clk_i,
  input  logic       rst_n_i,
  input  logic [2:0] sel_i,
  output logic       tick_o
);
  import wdt_pkg::*;

  logic [WIDTH-1:0] div_cnt;
  logic [7:0]       hit;

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      div_cnt <= '0;
    end else begin
      div_cnt <= div_cnt + 1'b1;
    end
  end

  // Each division fires when its low bits are all ones
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++) begin : g_div
      localparam int LOG2 = int'(WDT_DIV_LOG2[gi*5 +: 5]);
      assign hit[gi] = &div_cnt[LOG2-1:0];
    end
  endgenerate

  assign tick_o = hit[sel_i];

endmodule : wdt_prescaler

/* File: wdt_pulse.sv */
// Retriggerable pulse of a programmable number of cycles.
// Assumes start is a one-cycle pulse on the same clock.
`timescale 1ns/100ps
module wdt_pulse #(
  parameter int W = wdt_pkg::WDT_PULSE_W
) (
  input  logic         clk_i,
  input  logic         rst_n_i,
  input  logic         start_i,
  input  logic [W-1:0] len_i,
  output logic         active_o
);
  import wdt_pkg::*;

  logic [W-1:0] left;

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      left <= '0;
    end else if (start_i) begin
      left <= len_i;
    end else if (left != '0) begin
      left <= left - 1'b1;
    end
  end

  assign active_o = (left != '0);

endmodule : wdt_pulse

/* File: wdt_top.sv */
// Watchdog and interval timer with keyed word writes.
// Assumes a CPU bus on the same clock; external reset pin is async.
// What this block does
// - Counter and control writes need word access
// - Key 5A at shared address loads counter while running
// - Key A5 at shared address loads control
// - Reset control written by word only
// - A5 00 clears watchdog flag only
// - Key 5A copies reset enable and type
// - Byte reads at three separate addresses
// - Watchdog overflow drives overflow output low
// - Output low 132 or 130 cycles
// - Chip reset with output, 518 cycles
// - Type bit picks power-on or manual
// - External reset wins, clearing watchdog flag
// - Interval mode overflow requests interrupt
// - Interval flag and interrupt set together
// - Interrupt stands while interval flag set
// - Watchdog flag and output low together
// - Write beats coincident count pulse
// - No-reset overflow resets counter and control
// - Writes rejected while output low
// - Reads during low output do not arm
// - Prescale picks one of eight divisions
// - Stopped counter held at zero
// - Flag clears by read then write zero
// - Reset control kept across internal reset
`timescale 1ns/100ps
module wdt_top (
  input  logic                                CLK_I,
  input  logic                                RST_N_I,
  input  logic [$bits(wdt_pkg::WDT_ADDR_COUNT)-1:0] ADDR_I,
  input  logic [15:0]                         WDATA_I,
  input  logic                                WR_I,
  input  logic                                WORD_I,
  input  logic                                RD_I,
  output logic [7:0]                          RDATA_O,
  output logic                                OVF_OUT_N_O,
  output logic                                CHIP_RST_O,
  output logic                                CHIP_RST_MANUAL_O,
  output logic                                INTERVAL_IRQ_O
);
  import wdt_pkg::*;

  logic       rst_meta;
  logic       rst_n;
  logic [7:0] count;
  logic       iovf;
  logic       mode;
  logic       run;
  logic [2:0] cks;
  logic       watchdog_overflow_flag;
  logic       rst_en;
  logic       rst_type;
  logic       rst_kind;
  logic       iovf_armed;
  logic       watchdog_overflow_flag_armed;
  logic [7:0] rdata;
  logic       tick;
  logic       out_active;
  logic       chip_active;

  // Reset release through two flops; assertion is immediate
  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      rst_meta <= 1'b0;
      rst_n    <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n    <= rst_meta;
    end
  end

  // Bus decode
  wire [7:0] wr_hi    = WDATA_I[15:8];
  wire [7:0] wr_lo    = WDATA_I[7:0];
  wire       wr_ok    = WR_I && WORD_I && !out_active;
  wire       ctrl_hit = wr_ok && (ADDR_I == WDT_ADDR_CTRL_STAT);
  wire       rst_hit  = wr_ok && (ADDR_I == WDT_ADDR_RST_WR);
  wire       cnt_wr   = ctrl_hit && (wr_hi == WDT_KEY_COUNT);
  wire       cs_wr    = ctrl_hit && (wr_hi == WDT_KEY_CTRL);
  wire       rb_wr    = rst_hit && (wr_hi == WDT_KEY_RST_BITS);
  wire       fc_wr    = rst_hit && (wr_hi == WDT_KEY_FLAG_CLR)
                        && (wr_lo == WDT_FLAG_CLR_DATA);
  wire       rd_cs    = RD_I && (ADDR_I == WDT_ADDR_CTRL_STAT);
  wire       rd_cnt   = RD_I && (ADDR_I == WDT_ADDR_COUNT);
  wire       rd_rst   = RD_I && (ADDR_I == WDT_ADDR_RST_RD);
  wire       arm_ok   = !out_active;

  // Counting and overflow
  wire inc     = tick && run && !cnt_wr;
  wire ovf_evt = inc && (count == WDT_COUNT_MAX);
  wire wd_ovf  = ovf_evt && mode;
  wire it_ovf  = ovf_evt && !mode;

  // Flag clears need a prior read seen while the flag was set
  wire iovf_clr = cs_wr && !wr_lo[WDT_BIT_IOVF] && iovf_armed;
  wire watchdog_overflow_flag_clr = fc_wr && watchdog_overflow_flag_armed;
  wire [9:0] out_len = rst_en ? WDT_OUT_CYC_RST_EN : WDT_OUT_CYC_RST_DIS;

  wire [7:0] cs_view  = {iovf, mode, run, WDT_CTRL_RSVD, cks};
  wire [7:0] rst_view = {watchdog_overflow_flag, rst_en, rst_type, WDT_RST_RSVD};
  wire [7:0] next_rdata = rd_cs  ? cs_view  :
                          rd_cnt ? count    :
                          rd_rst ? rst_view : 8'h00;

  wdt_prescaler u_pre (
    .clk_i   (CLK_I),
    .rst_n_i (rst_n),
    .sel_i   (cks),
    .tick_o  (tick)
  );

  wdt_pulse u_out (
    .clk_i    (CLK_I),
    .rst_n_i  (rst_n),
    .start_i  (wd_ovf),
    .len_i    (out_len),
    .active_o (out_active)
  );

  wdt_pulse u_chip (
    .clk_i    (CLK_I),
    .rst_n_i  (rst_n),
    .start_i  (wd_ovf && rst_en),
    .len_i    (WDT_CHIP_RST_CYC),
    .active_o (chip_active)
  );

  // Counter: overflow reset, then stop, then write, then count
  always_ff @(posedge CLK_I or negedge rst_n) begin
    if (!rst_n) begin
      count <= WDT_COUNT_RST;
    end else if (wd_ovf || !run) begin
      count <= WDT_COUNT_RST;
    end else if (cnt_wr) begin
      count <= wr_lo;
    end else if (inc) begin
      count <= count + 1'b1;
    end
  end

  // Control and status fields
  always_ff @(posedge CLK_I or negedge rst_n) begin
    if (!rst_n) begin
      mode <= WDT_CTRL_STAT_RST[WDT_BIT_MODE];
      run  <= WDT_CTRL_STAT_RST[WDT_BIT_RUN];
      cks  <= WDT_CTRL_STAT_RST[WDT_BIT_CKS_HI:0];
    end else if (wd_ovf) begin
      mode <= WDT_CTRL_STAT_RST[WDT_BIT_MODE];
      run  <= WDT_CTRL_STAT_RST[WDT_BIT_RUN];
      cks  <= WDT_CTRL_STAT_RST[WDT_BIT_CKS_HI:0];
    end else if (cs_wr) begin
      mode <= wr_lo[WDT_BIT_MODE];
      run  <= wr_lo[WDT_BIT_RUN];
      cks  <= wr_lo[WDT_BIT_CKS_HI:0];
    end
  end

  // Interval flag: set beats clear
  always_ff @(posedge CLK_I or negedge rst_n) begin
    if (!rst_n) begin
      iovf       <= WDT_CTRL_STAT_RST[WDT_BIT_IOVF];
      iovf_armed <= 1'b0;
    end else if (it_ovf) begin
      iovf       <= 1'b1;
      iovf_armed <= iovf_armed;
    end else if (iovf_clr || wd_ovf) begin
      iovf       <= 1'b0;
      iovf_armed <= 1'b0;
    end else if (rd_cs && iovf && arm_ok) begin
      iovf_armed <= 1'b1;
    end
  end

  // Watchdog flag: set beats clear; cleared by the armed A5 00 write or by the pin reset
  always_ff @(posedge CLK_I or negedge rst_n) begin
    if (!rst_n) begin
      watchdog_overflow_flag       <= WDT_RST_CTRL_RST[WDT_BIT_WATCHDOG_OVERFLOW_FLAG];
      watchdog_overflow_flag_armed <= 1'b0;
    end else if (wd_ovf) begin
      watchdog_overflow_flag       <= 1'b1;
      watchdog_overflow_flag_armed <= 1'b0;
    end else if (watchdog_overflow_flag_clr) begin
      watchdog_overflow_flag       <= 1'b0;
      watchdog_overflow_flag_armed <= 1'b0;
    end else if ((rd_cs || rd_rst) && watchdog_overflow_flag && arm_ok) begin
      watchdog_overflow_flag_armed <= 1'b1;
    end
  end

  // Reset enable and type
  always_ff @(posedge CLK_I or negedge rst_n) begin
    if (!rst_n) begin
      rst_en   <= WDT_RST_CTRL_RST[WDT_BIT_RST_EN];
      rst_type <= WDT_RST_CTRL_RST[WDT_BIT_RST_TYPE];
      rst_kind <= 1'b0;
    end else begin
      if (rb_wr) begin
        rst_en   <= wr_lo[WDT_BIT_RST_EN];
        rst_type <= wr_lo[WDT_BIT_RST_TYPE];
      end
      if (wd_ovf && rst_en) begin
        rst_kind <= rst_type;
      end
    end
  end

  always_ff @(posedge CLK_I or negedge rst_n) begin
    if (!rst_n) begin
      rdata <= 8'h00;
    end else if (RD_I) begin
      rdata <= next_rdata;
    end
  end

  assign RDATA_O           = rdata;
  assign OVF_OUT_N_O       = !out_active;
  assign CHIP_RST_O        = chip_active;
  assign CHIP_RST_MANUAL_O = chip_active && rst_kind;
  assign INTERVAL_IRQ_O    = iovf;

  // Helper counters for long pulse lengths
  logic [9:0] low_len;
  logic [9:0] chip_len;
  always_ff @(posedge CLK_I or negedge rst_n) begin
    if (!rst_n) begin
      low_len  <= 10'h000;
      chip_len <= 10'h000;
    end else begin
      low_len  <= out_active ? low_len + 10'h001 : 10'h000;
      chip_len <= chip_active ? chip_len + 10'h001 : 10'h000;
    end
  end

  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (!rst_n);

  sequence s_wd_ovf_hit;
    wd_ovf && rst_en;
  endsequence
  sequence s_both_low;
    CHIP_RST_O && !OVF_OUT_N_O;
  endsequence

  a_byte_write_ignored: assert property (
    WR_I && !WORD_I && !wd_ovf |=> {mode, run, cks, rst_en} == $past({mode, run, cks, rst_en}))
    else $error("byte write changed a keyed register");
  a_count_key_load: assert property (
    cnt_wr && run |=> count == $past(wr_lo))
    else $error("keyed counter write did not load");
  a_ctrl_key_load: assert property (
    cs_wr && !wd_ovf |=> run == $past(wr_lo[WDT_BIT_RUN]) && cks == $past(wr_lo[2:0]))
    else $error("keyed control write did not load");
  a_flag_clear_keeps: assert property (
    fc_wr && watchdog_overflow_flag_armed && !wd_ovf |=> !watchdog_overflow_flag && {rst_en, rst_type} == $past({rst_en, rst_type}))
    else $error("flag clear wrong or touched reset bits");
  a_rst_bits_load: assert property (
    rb_wr && !wd_ovf |=> rst_en == $past(wr_lo[6]) && watchdog_overflow_flag == $past(watchdog_overflow_flag))
    else $error("reset bits write wrong");
  a_wd_ovf_output: assert property (
    wd_ovf |=> !OVF_OUT_N_O && watchdog_overflow_flag && !run && count == 8'h00)
    else $error("watchdog overflow effects missing");
  a_out_pulse_len: assert property (
    $rose(OVF_OUT_N_O) |-> low_len == (rst_en ? WDT_OUT_CYC_RST_EN : WDT_OUT_CYC_RST_DIS))
    else $error("overflow output length wrong");
  a_chip_rst_start: assert property (
    s_wd_ovf_hit |=> s_both_low ##1 CHIP_RST_O[*8])
    else $error("chip reset not with overflow output");
  a_chip_rst_len: assert property (
    $fell(CHIP_RST_O) |-> chip_len == WDT_CHIP_RST_CYC)
    else $error("chip reset length wrong");
  a_irq_on_ovf: assert property (
    it_ovf |=> INTERVAL_IRQ_O && iovf && count == 8'h00)
    else $error("interval overflow missed");
  a_irq_held: assert property (
    iovf && !cs_wr && !wd_ovf |=> INTERVAL_IRQ_O)
    else $error("interrupt dropped while flag set");
  a_write_locked: assert property (
    !OVF_OUT_N_O && WR_I |=> {rst_en, rst_type, cks, mode} == $past({rst_en, rst_type, cks, mode}))
    else $error("write accepted while output low");
  a_stop_zero: assert property (
    !run |=> count == 8'h00)
    else $error("stopped counter not zero");
  a_reset_type_pick: assert property (
    s_wd_ovf_hit |=> CHIP_RST_MANUAL_O == $past(rst_type))
    else $error("chip reset type does not follow type bit");
  a_no_chip_rst: assert property (
    wd_ovf && !rst_en |=> !CHIP_RST_O && !run && count == 8'h00)
    else $error("disabled overflow reset the chip or kept the timer");
  a_low_no_arm: assert property (
    !OVF_OUT_N_O && !watchdog_overflow_flag_armed |=> !watchdog_overflow_flag_armed)
    else $error("flag read armed while output low");
  a_low_with_flag: assert property (
    $fell(OVF_OUT_N_O) |-> watchdog_overflow_flag)
    else $error("output low without watchdog flag");

endmodule : wdt_top

/* File: wdt_cpu_model.sv */
// CPU-side bus master model for the watchdog register bus.
// Assumes requests are launched at rising edges and taken at the next one.
`timescale 1ns/100ps
module wdt_cpu_model (
  input  wire logic        clk_i,
  input  wire logic [7:0]  rdata_i,
  output logic      [15:0] addr_o,
  output logic      [15:0] wdata_o,
  output logic             wr_o,
  output logic             word_o,
  output logic             rd_o
);
  initial begin
    addr_o  = 16'h0000;
    wdata_o = 16'h0000;
    wr_o    = 1'b0;
    word_o  = 1'b0;
    rd_o    = 1'b0;
  end

  // Keyed write, word or byte sized
  task automatic wr(input logic [15:0] a, input logic [15:0] d, input logic w);
    @(posedge clk_i);
    addr_o  <= a;
    wdata_o <= d;
    word_o  <= w;
    wr_o    <= 1'b1;
    @(posedge clk_i);
    wr_o    <= 1'b0;
    wdata_o <= ~d;
  endtask : wr

  // Single byte read, data one edge after the strobe
  task automatic rd(input logic [15:0] a, output logic [7:0] d);
    @(posedge clk_i);
    addr_o <= a;
    rd_o   <= 1'b1;
    @(posedge clk_i);
    rd_o   <= 1'b0;
    #1;
    d = rdata_i;
  endtask : rd
endmodule : wdt_cpu_model

/* File: tb.sv */
// Self-checking bench for the watchdog and interval timer.
// Assumes wdt_top, its package and the CPU model are compiled first.
`timescale 1ns/100ps
module tb;
  import wdt_pkg::*;
  logic        clk;
  logic        rst_n;
  logic [15:0] addr;
  logic [15:0] wdata;
  logic        wr;
  logic        word;
  logic        rd;
  logic [7:0]  rdata;
  logic        ovf_n;
  logic        chip_rst;
  logic        manual;
  logic        irq;
  int          num_errors = 0;
  int          checks     = 0;
  int          cyc        = 0;
  int          lo_n       = 0;
  int          rs_n       = 0;
  logic [7:0]  v;

  wdt_top dut (.CLK_I(clk), .RST_N_I(rst_n), .ADDR_I(addr), .WDATA_I(wdata), .WR_I(wr), .WORD_I(word),
               .RD_I(rd), .RDATA_O(rdata), .OVF_OUT_N_O(ovf_n), .CHIP_RST_O(chip_rst),
               .CHIP_RST_MANUAL_O(manual), .INTERVAL_IRQ_O(irq));
  wdt_cpu_model cpu (.clk_i(clk), .rdata_i(rdata), .addr_o(addr), .wdata_o(wdata), .wr_o(wr),
                     .word_o(word), .rd_o(rd));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  always @(posedge clk) begin
    cyc++;
    if (ovf_n === 1'b0) lo_n++;
    if (chip_rst === 1'b1) rs_n++;
    if (cyc > 20000) begin
      num_errors++;
      report_and_stop();
    end
  end

  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk8

  task automatic chkn(input int got, input int exp);
    checks++;
    if (got != exp) begin
      num_errors++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chkn

  task automatic rdchk(input logic [15:0] a, input logic [7:0] exp);
    logic [7:0] d;
    cpu.rd(a, d);
    chk8(d, exp);
  endtask : rdchk

  // Wait for the overflow output to fall, bounded
  task automatic wait_low();
    int n;
    n = 0;
    while (ovf_n !== 1'b0 && n < 1000) begin
      @(posedge clk);
      n++;
    end
    #1;
    chk8({7'h0, ovf_n}, 8'h00);
  endtask : wait_low

  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : report_and_stop

  initial begin
    int n;
    rst_n = 1'b0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    // Reset values, refused writes, keyed loads
    rdchk(WDT_ADDR_CTRL_STAT, 8'h18);
    rdchk(WDT_ADDR_COUNT, 8'h00);
    rdchk(WDT_ADDR_RST_RD, 8'h1F);
    cpu.wr(WDT_ADDR_CTRL_STAT, 16'hA560, 1'b0);
    rdchk(WDT_ADDR_CTRL_STAT, 8'h18);
    cpu.wr(WDT_ADDR_RST_WR, 16'h5A60, 1'b0);
    rdchk(WDT_ADDR_RST_RD, 8'h1F);
    cpu.wr(WDT_ADDR_CTRL_STAT, 16'h5A33, 1'b1);
    rdchk(WDT_ADDR_COUNT, 8'h00);
    rdchk(16'hFFC0, 8'h00);
    cpu.wr(WDT_ADDR_CTRL_STAT, 16'hA527, 1'b1);
    rdchk(WDT_ADDR_CTRL_STAT, 8'h3F);
    cpu.wr(WDT_ADDR_CTRL_STAT, 16'h5A42, 1'b1);
    rdchk(WDT_ADDR_COUNT, 8'h42);
    cpu.wr(WDT_ADDR_CTRL_STAT, 16'hA507, 1'b1);
    rdchk(WDT_ADDR_CTRL_STAT, 8'h1F);
    rdchk(WDT_ADDR_COUNT, 8'h00);
    $display("test access done");
    // Interval mode
    cpu.wr(WDT_ADDR_CTRL_STAT, 16'hA520, 1'b1);
    n = 0;
    while (irq !== 1'b1 && n < 1000) begin
      @(posedge clk);
      n++;
    end
    #1;
    chk8({7'h0, irq}, 8'h01);
    rdchk(WDT_ADDR_CTRL_STAT, 8'hB8);
    chk8({7'h0, irq}, 8'h01);
    cpu.wr(WDT_ADDR_CTRL_STAT, 16'hA520, 1'b1);
    rdchk(WDT_ADDR_CTRL_STAT, 8'h38);
    chk8({7'h0, irq}, 8'h00);
    cpu.wr(WDT_ADDR_CTRL_STAT, 16'hA500, 1'b1);
    $display("test interval done");
    // Watchdog with chip reset, manual type
    cpu.wr(WDT_ADDR_RST_WR, 16'h5A60, 1'b1);
    rdchk(WDT_ADDR_RST_RD, 8'h7F);
    cpu.wr(WDT_ADDR_CTRL_STAT, 16'hA560, 1'b1);
    repeat (3) begin
      repeat (300) @(posedge clk);
      cpu.wr(WDT_ADDR_CTRL_STAT, 16'h5A00, 1'b1);
      #1;
      chk8({7'h0, ovf_n}, 8'h01);
    end
    lo_n = 0;
    rs_n = 0;
    wait_low();
    chk8({6'h0, manual, chip_rst}, 8'h03);
    cpu.rd(WDT_ADDR_RST_RD, v);
    repeat (600) @(posedge clk);
    chkn(lo_n, WDT_OUT_STATES_RST_EN);
    chkn(rs_n, WDT_CHIP_RST_STATES);
    cpu.wr(WDT_ADDR_RST_WR, 16'hA500, 1'b1);
    rdchk(WDT_ADDR_RST_RD, 8'hFF);
    cpu.wr(WDT_ADDR_RST_WR, 16'hA500, 1'b1);
    rdchk(WDT_ADDR_RST_RD, 8'h7F);
    rdchk(WDT_ADDR_CTRL_STAT, 8'h18);
    $display("test watchdog reset done");
    // Watchdog without chip reset
    cpu.wr(WDT_ADDR_RST_WR, 16'h5A00, 1'b1);
    rdchk(WDT_ADDR_RST_RD, 8'h1F);
    cpu.wr(WDT_ADDR_CTRL_STAT, 16'hA560, 1'b1);
    lo_n = 0;
    rs_n = 0;
    wait_low();
    cpu.wr(WDT_ADDR_RST_WR, 16'h5A60, 1'b1);
    cpu.wr(WDT_ADDR_CTRL_STAT, 16'hA520, 1'b1);
    repeat (200) @(posedge clk);
    chkn(lo_n, WDT_OUT_STATES_RST_DIS);
    chkn(rs_n, 0);
    rdchk(WDT_ADDR_RST_RD, 8'h9F);
    rdchk(WDT_ADDR_CTRL_STAT, 8'h18);
    $display("test watchdog no reset done");
    // External reset during a power-on type chip reset
    cpu.wr(WDT_ADDR_RST_WR, 16'h5A40, 1'b1);
    rdchk(WDT_ADDR_RST_RD, 8'hDF);
    cpu.wr(WDT_ADDR_CTRL_STAT, 16'hA560, 1'b1);
    wait_low();
    chk8({6'h0, manual, chip_rst}, 8'h01);
    rst_n <= 1'b0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    #1;
    chk8({7'h0, ovf_n}, 8'h01);
    chk8({6'h0, manual, chip_rst}, 8'h00);
    rdchk(WDT_ADDR_RST_RD, 8'h1F);
    $display("test external reset done");
    report_and_stop();
  end
endmodule : tb
